// ===== shared/partner_capture_pkg.sv
/*
 * Constants and types for the link partner ability capture registers.
 * Assumes an APB slave with 12-bit byte addresses and 32-bit data.
 */
package partner_capture_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned WORD_W = 16;

  // Register indices; byte address is four times the index
  localparam logic [7:0] BASE_IDX = 8'h04;
  localparam logic [7:0] NEXT_IDX = 8'h05;
  localparam logic [7:0] CTRL_IDX = 8'h07;
  localparam logic [7:0] STAT_IDX = 8'h08;
  localparam logic [ADDR_W-1:0] BASE_ADDR = {2'h0, BASE_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] NEXT_ADDR = {2'h0, NEXT_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] STAT_ADDR = {2'h0, STAT_IDX, 2'h0};

  // Field positions; bits 15 and 14 shared by both captured words, bit 13 remote fault in the base word only
  localparam int unsigned MORE_PAGES_BIT = 15;
  localparam int unsigned ACK_BIT        = 14;
  localparam int unsigned RF_BIT         = 13;

  // Bits the base word can ever hold; 12:10 stay zero
  localparam logic [WORD_W-1:0] BASE_KEEP_MASK = 16'hE3FF;
  localparam logic [WORD_W-1:0] NEXT_KEEP_MASK = 16'hFFFF;
  localparam logic [WORD_W-1:0] BASE_RESET     = 16'h0000;
  localparam logic [WORD_W-1:0] NEXT_RESET     = 16'h0000;
  // Refresh after success touches only the page-control bits
  localparam logic [WORD_W-1:0] REFRESH_MASK   = 16'hC000;

  // Control: bit 0 enables capture
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam logic        CTRL_EN_RESET = 1'b1;
  // Status: sticky page flags, live completion level
  localparam int unsigned STAT_BASE_BIT = 0;
  localparam int unsigned STAT_NEXT_BIT = 1;
  localparam int unsigned STAT_DONE_BIT = 2;
  localparam logic [2:0]  STAT_RESET    = 3'h0;

  typedef struct packed {
    logic       partner_more_pages_request;
    logic       partner_ack;
    logic       partner_remote_fault;
    logic [2:0] reserved;
    logic       partner_four_pair_capable;
    logic       partner_fast_full_duplex;
    logic       partner_fast_capable;
    logic       partner_ten_full_duplex;
    logic       partner_ten_capable;
    logic [4:0] selector;
  } base_page_t;

  typedef struct packed {
    logic        partner_more_pages_request;
    logic        partner_ack;
    logic        message_page_flag;
    logic        partner_can_comply;
    logic        toggle;
    logic [10:0] code;
  } next_page_t;

  typedef enum logic [1:0] {
    BUS_SETUP  = 2'h1,
    BUS_ANSWER = 2'h2
  } bus_state_t;

endpackage : partner_capture_pkg

// ===== verilog/capture_word.sv
/*
 * One read-only capture word, loaded only by hardware.
 * Assumes load and load_data come from logic on the same clock.
 */
`timescale 1ns/100ps
module capture_word #(
  parameter int unsigned        W         = 16,
  parameter logic [W-1:0]       KEEP_MASK = '1,
  parameter logic [W-1:0]       RESET_VAL = '0
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         load,
  input  wire logic [W-1:0] load_data,
  output logic      [W-1:0] value
);

  logic [W-1:0] word_reg;
  logic [W-1:0] word_next;

  // Masked bits never store, so reserved fields read zero
  always_comb begin
    word_next = word_reg;
    if (load) begin
      word_next = load_data & KEEP_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_reg <= RESET_VAL;
    end else begin
      word_reg <= word_next;
    end
  end

  assign value = word_reg;

  chk_masked_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (word_reg & ~KEEP_MASK) == '0)
    else $error("Masked capture bits are not zero");

  chk_load_stores: assert property (@(posedge pclk) disable iff (!presetn)
    load |=> word_reg == ($past(load_data) & KEEP_MASK))
    else $error("Capture word did not take loaded data");

  chk_hold_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !load |=> $stable(word_reg))
    else $error("Capture word changed without a load");

endmodule : capture_word

// ===== verilog/partner_ability_capture_regs.sv
/*
 * APB register bank holding what the remote link partner advertised
 * during negotiation: its base ability word and its next-page word.
 * Assumes the negotiation engine runs on pclk and strobes whole words.
 */
// The APB register port was decided locally.
// Function
// - Base abilities held read-only, bits 15:14 refreshed by a next page after success while base bit 15 is set
// - Bit 15 shows partner wants more pages
// - Bit 14 shows partner acknowledge, hardware driven
// - Base bit 13 shows partner remote fault
// - Base bits 12 to 10 read zero
// - Base bit 9 four-pair fast capability
// - Base bit 8 fast full duplex
// - Base bit 7 fast twisted-pair capability
// - Base bit 6 ten full duplex
// - Base bit 5 ten capability
// - Base bits 4 to 0 selector, reset zero
// - Next-page bit 13 flags message page
// - Next-page bit 12 partner can comply
// - Next-page bits 10 to 0 code, reset zero
`timescale 1ns/100ps
module partner_ability_capture_regs (
  input  wire logic                                        pclk,
  input  wire logic                                        presetn,
  input  wire logic                                        psel,
  input  wire logic                                        penable,
  input  wire logic                                        pwrite,
  input  wire logic [partner_capture_pkg::ADDR_W-1:0]      paddr,
  input  wire logic [partner_capture_pkg::DATA_W-1:0]      pwdata,
  input  wire logic [3:0]                                  pstrb,
  output logic      [partner_capture_pkg::DATA_W-1:0]      prdata,
  output logic                                             pready,
  output logic                                             pslverr,
  input  wire logic                                        base_page_strobe,
  input  wire partner_capture_pkg::base_page_t             base_page_word,
  input  wire logic                                        next_page_strobe,
  input  wire partner_capture_pkg::next_page_t             next_page_word,
  input  wire logic                                        negotiation_complete
);

  localparam int unsigned W = partner_capture_pkg::WORD_W;
  localparam int unsigned D = partner_capture_pkg::DATA_W;

  logic [W-1:0]                    base_value;
  logic [W-1:0]                    next_value;
  logic                            base_load;
  logic [W-1:0]                    base_load_data;
  logic                            next_load;
  logic                            capture_en_reg;
  logic                            capture_en_next;
  logic [2:0]                      status_reg;
  logic [2:0]                      status_next;
  partner_capture_pkg::bus_state_t bus_state_reg;
  partner_capture_pkg::bus_state_t bus_state_next;
  logic [D-1:0]                    prdata_reg;
  logic [D-1:0]                    prdata_next;
  logic                            pready_reg;
  logic                            pready_next;
  logic                            pslverr_reg;
  logic                            pslverr_next;
  logic                            setup_phase;
  logic                            access_done;
  logic                            wr_ctrl;
  logic                            wr_stat;
  logic                            refresh;

  assign setup_phase = psel && !penable;
  // Writes commit only at the edge that ends the access, as the master expects
  assign access_done = psel && penable && pready_reg;
  assign wr_ctrl = access_done && pwrite && (paddr == partner_capture_pkg::CTRL_ADDR)
                   && pstrb[0];
  assign wr_stat = access_done && pwrite && (paddr == partner_capture_pkg::STAT_ADDR)
                   && pstrb[0];

  // After success with next pages, page-control bits follow the partner
  assign refresh = next_page_strobe && negotiation_complete
                   && base_value[partner_capture_pkg::MORE_PAGES_BIT];

  // Fresh base page wins over a refresh in the same cycle
  always_comb begin
    base_load      = 1'b0;
    base_load_data = base_value;
    if (capture_en_reg && base_page_strobe) begin
      base_load      = 1'b1;
      base_load_data = base_page_word;
    end else if (capture_en_reg && refresh) begin
      base_load      = 1'b1;
      base_load_data = (base_value & ~partner_capture_pkg::REFRESH_MASK)
                       | (next_page_word & partner_capture_pkg::REFRESH_MASK);
    end
  end

  // Only the engine strobe loads; the bus has no path here
  assign next_load = capture_en_reg && next_page_strobe;

  capture_word #(
    .W         (W),
    .KEEP_MASK (partner_capture_pkg::BASE_KEEP_MASK),
    .RESET_VAL (partner_capture_pkg::BASE_RESET)
  ) u_base_word (
    .pclk      (pclk),
    .presetn   (presetn),
    .load      (base_load),
    .load_data (base_load_data),
    .value     (base_value)
  );

  capture_word #(
    .W         (W),
    .KEEP_MASK (partner_capture_pkg::NEXT_KEEP_MASK),
    .RESET_VAL (partner_capture_pkg::NEXT_RESET)
  ) u_next_word (
    .pclk      (pclk),
    .presetn   (presetn),
    .load      (next_load),
    .load_data (next_page_word),
    .value     (next_value)
  );

  // Control and status; a hardware set beats a software clear
  always_comb begin
    capture_en_next = capture_en_reg;
    status_next     = status_reg;
    if (wr_ctrl) begin
      capture_en_next = pwdata[partner_capture_pkg::CTRL_EN_BIT];
    end
    if (wr_stat) begin
      status_next[partner_capture_pkg::STAT_BASE_BIT] =
        status_reg[partner_capture_pkg::STAT_BASE_BIT]
        && !pwdata[partner_capture_pkg::STAT_BASE_BIT];
      status_next[partner_capture_pkg::STAT_NEXT_BIT] =
        status_reg[partner_capture_pkg::STAT_NEXT_BIT]
        && !pwdata[partner_capture_pkg::STAT_NEXT_BIT];
    end
    if (capture_en_reg && base_page_strobe) begin
      status_next[partner_capture_pkg::STAT_BASE_BIT] = 1'b1;
    end
    if (next_load) begin
      status_next[partner_capture_pkg::STAT_NEXT_BIT] = 1'b1;
    end
    status_next[partner_capture_pkg::STAT_DONE_BIT] = negotiation_complete;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_en_reg <= partner_capture_pkg::CTRL_EN_RESET;
      status_reg     <= partner_capture_pkg::STAT_RESET;
    end else begin
      capture_en_reg <= capture_en_next;
      status_reg     <= status_next;
    end
  end

  // Answer one cycle after setup, so every access has no wait state
  always_comb begin
    bus_state_next = bus_state_reg;
    prdata_next    = '0;
    pready_next    = 1'b0;
    pslverr_next   = 1'b0;
    unique case (bus_state_reg)
      partner_capture_pkg::BUS_SETUP: begin
        if (setup_phase) begin
          bus_state_next = partner_capture_pkg::BUS_ANSWER;
          pready_next    = 1'b1;
          unique case (paddr)
            partner_capture_pkg::BASE_ADDR: begin
              prdata_next = pwrite ? '0 : {16'h0000, base_value};
            end
            partner_capture_pkg::NEXT_ADDR: begin
              prdata_next = pwrite ? '0 : {16'h0000, next_value};
            end
            partner_capture_pkg::CTRL_ADDR: begin
              prdata_next = pwrite ? '0 : {31'h00000000, capture_en_reg};
            end
            partner_capture_pkg::STAT_ADDR: begin
              prdata_next = pwrite ? '0 : {29'h00000000, status_reg};
            end
            default: begin
              pslverr_next = 1'b1;
            end
          endcase
        end
      end
      partner_capture_pkg::BUS_ANSWER: begin
        bus_state_next = partner_capture_pkg::BUS_SETUP;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_state_reg <= partner_capture_pkg::BUS_SETUP;
      prdata_reg    <= '0;
      pready_reg    <= 1'b0;
      pslverr_reg   <= 1'b0;
    end else begin
      bus_state_reg <= bus_state_next;
      prdata_reg    <= prdata_next;
      pready_reg    <= pready_next;
      pslverr_reg   <= pslverr_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // Checks on the captured fields and the bus answer
  chk_more_pages_read: assert property (@(posedge pclk) disable iff (!presetn)
    setup_phase && !pwrite && paddr == partner_capture_pkg::BASE_ADDR
    |=> pready && prdata[partner_capture_pkg::MORE_PAGES_BIT]
        == $past(base_value[partner_capture_pkg::MORE_PAGES_BIT]))
    else $error("Read of more-pages bit wrong");

  chk_ack_from_engine: assert property (@(posedge pclk) disable iff (!presetn)
    capture_en_reg && base_page_strobe
    |=> base_value[partner_capture_pkg::ACK_BIT] == $past(base_page_word.partner_ack))
    else $error("Acknowledge bit not taken from incoming page");

  chk_fault_ability: assert property (@(posedge pclk) disable iff (!presetn)
    capture_en_reg && base_page_strobe
    |=> base_value[13] == $past(base_page_word.partner_remote_fault)
        && base_value[9] == $past(base_page_word.partner_four_pair_capable))
    else $error("Fault or four-pair bit wrong");

  chk_speed_fields: assert property (@(posedge pclk) disable iff (!presetn)
    capture_en_reg && base_page_strobe
    |=> base_value[8:6] == {$past(base_page_word.partner_fast_full_duplex),
                           $past(base_page_word.partner_fast_capable),
                           $past(base_page_word.partner_ten_full_duplex)})
    else $error("Speed ability bits wrong");

  chk_ten_selector: assert property (@(posedge pclk) disable iff (!presetn)
    capture_en_reg && base_page_strobe
    |=> base_value[5:0] == {$past(base_page_word.partner_ten_capable),
                           $past(base_page_word.selector)})
    else $error("Ten capability or selector wrong");

  chk_reserved_read: assert property (@(posedge pclk) disable iff (!presetn)
    setup_phase && !pwrite && paddr == partner_capture_pkg::BASE_ADDR
    |=> prdata[12:10] == 3'h0 && prdata[31:16] == 16'h0000)
    else $error("Reserved base bits read nonzero");

  chk_next_fields: assert property (@(posedge pclk) disable iff (!presetn)
    next_load |=> next_value[13:12] == {$past(next_page_word.message_page_flag),
                                       $past(next_page_word.partner_can_comply)}
                  && next_value[10:0] == $past(next_page_word.code))
    else $error("Next-page fields wrong");

  chk_write_no_effect: assert property (@(posedge pclk) disable iff (!presetn)
    setup_phase && pwrite && !base_page_strobe && !next_page_strobe
    |=> $stable(base_value) && $stable(next_value))
    else $error("Bus write changed a captured word");

  chk_refresh_update: assert property (@(posedge pclk) disable iff (!presetn)
    capture_en_reg && refresh && !base_page_strobe
    |=> base_value[15:14] == $past(next_page_word[15:14])
        && base_value[13:0] == $past(base_value[13:0]))
    else $error("Base word not refreshed after success");

  chk_answer_once: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("Ready held longer than one cycle");

  chk_next_read: assert property (@(posedge pclk) disable iff (!presetn)
    setup_phase && !pwrite && paddr == partner_capture_pkg::NEXT_ADDR
    |=> pready && !pslverr && prdata == {16'h0000, $past(next_value)})
    else $error("Read of next-page word wrong");

  // Unmapped offsets answer at once with an error and zero data
  chk_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
    setup_phase && paddr != partner_capture_pkg::BASE_ADDR
    && paddr != partner_capture_pkg::NEXT_ADDR && paddr != partner_capture_pkg::CTRL_ADDR
    && paddr != partner_capture_pkg::STAT_ADDR
    |=> pready && pslverr && prdata == '0)
    else $error("Unmapped access not refused");

  // With capture off the engine cannot touch either word
  chk_drop_disabled: assert property (@(posedge pclk) disable iff (!presetn)
    !capture_en_reg |=> $stable(base_value) && $stable(next_value))
    else $error("Captured word changed while capture disabled");

  // A page arriving with a clear in the same cycle still marks the flag
  chk_page_seen: assert property (@(posedge pclk) disable iff (!presetn)
    capture_en_reg && base_page_strobe |=> status_reg[partner_capture_pkg::STAT_BASE_BIT])
    else $error("Base page flag not set");

  // Guarded by the previous reset level so a release cannot false-fire
  chk_done_live: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn)
    |-> status_reg[partner_capture_pkg::STAT_DONE_BIT] == $past(negotiation_complete))
    else $error("Completion status does not follow the engine");

  chk_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
    access_done && pwrite && paddr == partner_capture_pkg::CTRL_ADDR && pstrb[0]
    |=> capture_en_reg == $past(pwdata[partner_capture_pkg::CTRL_EN_BIT]))
    else $error("Capture enable write not taken");

  cov_base_read: cover property (@(posedge pclk) disable iff (!presetn)
    base_load ##[1:20] (pready && !pslverr && bus_state_reg == partner_capture_pkg::BUS_ANSWER));
  cov_refresh: cover property (@(posedge pclk) disable iff (!presetn)
    capture_en_reg && refresh && !base_page_strobe);
  cov_unmapped: cover property (@(posedge pclk) disable iff (!presetn)
    pready && pslverr);
  cov_disabled_drop: cover property (@(posedge pclk) disable iff (!presetn)
    !capture_en_reg && base_page_strobe);

endmodule : partner_ability_capture_regs

// ===== bench/partner_model.sv
/*
 * Behavioural negotiation engine that hands received partner pages over.
 * Assumes its tasks are called right after a rising pclk edge.
 */
`timescale 1ns/100ps
module partner_model (
  input  wire logic                       pclk,
  output logic                            base_page_strobe,
  output partner_capture_pkg::base_page_t base_page_word,
  output logic                            next_page_strobe,
  output partner_capture_pkg::next_page_t next_page_word,
  output logic                            negotiation_complete
);
  // Quiet engine until the bench asks for a page
  initial begin
    base_page_strobe     = 1'b0;
    base_page_word       = '0;
    next_page_strobe     = 1'b0;
    next_page_word       = '0;
    negotiation_complete = 1'b0;
  end

  // One-cycle base pulse; idle word inverted so stale data cannot pass
  task automatic send_base(input logic [15:0] w);
    base_page_word   <= w;
    base_page_strobe <= 1'b1;
    @(posedge pclk);
    base_page_strobe <= 1'b0;
    base_page_word   <= ~w;
  endtask : send_base

  // One-cycle next-page pulse, same idle policy
  task automatic send_next(input logic [15:0] w);
    next_page_word   <= w;
    next_page_strobe <= 1'b1;
    @(posedge pclk);
    next_page_strobe <= 1'b0;
    next_page_word   <= ~w;
  endtask : send_next

  // Negotiation success level
  task automatic set_complete(input logic v);
    negotiation_complete <= v;
    @(posedge pclk);
  endtask : set_complete
endmodule : partner_model

// ===== bench/tb_top.sv
/*
 * Self-checking bench for the partner ability capture bank.
 * Assumes the APB slave answers on its own and the engine model drives pages.
 */
`timescale 1ns/100ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, (got), (exp)); end end
module tb_top;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h00000000;
  logic [3:0]  pstrb   = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        base_page_strobe;
  logic        next_page_strobe;
  logic        negotiation_complete;
  partner_capture_pkg::base_page_t base_page_word;
  partner_capture_pkg::next_page_t next_page_word;
  int          n_fail       = 0;
  int          total_checks = 0;
  int          cycles       = 0;
  logic [31:0] rng_state    = 32'h00000045;
  logic [31:0] rdata;
  logic        rerr;
  logic [15:0] w;
  logic [15:0] nw;
  logic [15:0] base_exp;

  partner_ability_capture_regs i_partner_ability_capture_regs (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .base_page_strobe(base_page_strobe), .base_page_word(base_page_word),
    .next_page_strobe(next_page_strobe), .next_page_word(next_page_word),
    .negotiation_complete(negotiation_complete));

  partner_model i_partner_model (
    .pclk(pclk), .base_page_strobe(base_page_strobe), .base_page_word(base_page_word),
    .next_page_strobe(next_page_strobe), .next_page_word(next_page_word),
    .negotiation_complete(negotiation_complete));

  // 25 MHz clock
  always #20 pclk = ~pclk;

  // Hang guard, far above the few hundred cycles needed
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      conclude();
    end
  end

  // Xorshift source, fixed start for repeatable runs
  function automatic logic [15:0] next_rand();
    rng_state = rng_state ^ (rng_state << 13);
    rng_state = rng_state ^ (rng_state >> 17);
    rng_state = rng_state ^ (rng_state << 5);
    return rng_state[15:0];
  endfunction : next_rand

  // Stored base view: reserved field always zero
  function automatic logic [15:0] base_view(input logic [15:0] v);
    return {v[15:13], 3'h0, v[9:0]};
  endfunction : base_view

  // APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Read a mapped word and compare
  task automatic read_check(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    `CHK(rdata, exp)
    `CHK(rerr, 1'b0)
  endtask : read_check

  task automatic conclude();
    if (n_fail == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  // Main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    read_check(partner_capture_pkg::BASE_ADDR, 32'h00000000);
    read_check(partner_capture_pkg::NEXT_ADDR, 32'h00000000);
    read_check(partner_capture_pkg::CTRL_ADDR, 32'h00000001);
    read_check(partner_capture_pkg::STAT_ADDR, 32'h00000000);
    // Random base pages, all-ones and all-zeros first
    for (int i = 0; i < 24; i++) begin
      w = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : next_rand();
      i_partner_model.send_base(w);
      base_exp = base_view(w);
      read_check(partner_capture_pkg::BASE_ADDR, {16'h0000, base_exp});
    end
    // Random next pages; without success the base word stays put
    for (int i = 0; i < 24; i++) begin
      nw = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : next_rand();
      i_partner_model.send_next(nw);
      read_check(partner_capture_pkg::NEXT_ADDR, {16'h0000, nw});
    end
    read_check(partner_capture_pkg::BASE_ADDR, {16'h0000, base_exp});
    read_check(partner_capture_pkg::STAT_ADDR, 32'h00000003);
    // Software writes bounce off both words; ack bit left clear
    apb(1'b1, partner_capture_pkg::BASE_ADDR, 32'hFFFFFFFF);
    `CHK(rerr, 1'b0)
    apb(1'b1, partner_capture_pkg::NEXT_ADDR, ~{16'h0000, nw} & 32'hFFFFBFFF);
    read_check(partner_capture_pkg::BASE_ADDR, {16'h0000, base_exp});
    read_check(partner_capture_pkg::NEXT_ADDR, {16'h0000, nw});
    // Unmapped address
    apb(1'b0, 12'h040, 32'h00000000);
    `CHK(rerr, 1'b1)
    `CHK(rdata, 32'h00000000)
    // Capture disabled drops pages
    apb(1'b1, partner_capture_pkg::CTRL_ADDR, 32'h00000000);
    i_partner_model.send_base(~base_exp);
    read_check(partner_capture_pkg::BASE_ADDR, {16'h0000, base_exp});
    apb(1'b1, partner_capture_pkg::CTRL_ADDR, 32'h00000001);
    // Control write with its low byte lane off is ignored
    pstrb <= 4'h0;
    apb(1'b1, partner_capture_pkg::CTRL_ADDR, 32'h00000000);
    pstrb <= 4'hF;
    read_check(partner_capture_pkg::CTRL_ADDR, 32'h00000001);
    apb(1'b1, partner_capture_pkg::STAT_ADDR, 32'h00000003);
    read_check(partner_capture_pkg::STAT_ADDR, 32'h00000000);
    // After success a next page refreshes base bits 15:14 when base bit 15 is set
    i_partner_model.set_complete(1'b1);
    for (int i = 0; i < 8; i++) begin
      w = next_rand();
      w[15] = i[0];
      i_partner_model.send_base(w);
      base_exp = base_view(w);
      nw = next_rand();
      i_partner_model.send_next(nw);
      if (w[15]) begin
        base_exp[15:14] = nw[15:14];
      end
      read_check(partner_capture_pkg::BASE_ADDR, {16'h0000, base_exp});
      read_check(partner_capture_pkg::NEXT_ADDR, {16'h0000, nw});
    end
    read_check(partner_capture_pkg::STAT_ADDR, 32'h00000007);
    // Reset in mid-run clears both words
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    read_check(partner_capture_pkg::BASE_ADDR, 32'h00000000);
    read_check(partner_capture_pkg::NEXT_ADDR, 32'h00000000);
    conclude();
  end
endmodule : tb_top
